// >>> rtl/acmp_top.sv
/*
  Control and status logic around two analog comparators: control
  registers, output polarity, pin routing, timer synchronisation and
  edge flags. Assumes the analog cores return one raw bit each,
  asynchronously, and that the timer clock and pin direction inputs
  are synchronous to MCLK.
*/
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
// How it works
// - Result bit 6 reads 1 when positive input wins, inverted if set.
// - Pin enable bit 5 drives pin when direction bit clear.
// - Invert bit 4 flips result before status, pin, timer, edges.
// - Speed bit 2 resets to 1; zero asks core for low power.
// - Hysteresis bit 1 is forwarded to the analog core.
// - Sync bit 0 updates timer and pin output on timer clock fall.
// - Rising enable bit 7 of control B flags positive result edges.
// - Falling enable bit 6 of control B flags negative result edges.
// - Positive channel bits 5-4 pick pin, DAC, fixed ref, shared/ground.
// - Negative channel bits 1-0 pick one of four shared pins.
// - Mirror register shows both results in bits 0 and 1.
// - Disabled comparator outputs its invert bit and disconnects its inputs.
// - Internal result registers once per instruction cycle.
// - Software clears flag; a same-cycle edge keeps it set.
// - Toggling invert or enable can flag an edge while disabled.
module acmp_top
  import acmp_pkg::*;
(
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET_N,
  // Register port.
  input wire logic [acmp_pkg::ADDR_W-1:0] ADDR,
  input wire logic [acmp_pkg::DATA_W-1:0] WDATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [acmp_pkg::DATA_W-1:0] RDATA,
  // Analog cores.
  input wire logic [acmp_pkg::NUM_CMP-1:0] CMP_RAW,
  output logic [acmp_pkg::NUM_CMP-1:0] CMP_POWER_ON,
  output logic [acmp_pkg::NUM_CMP-1:0] SPEED_POWER,
  output logic [acmp_pkg::NUM_CMP-1:0] HYST_EN,
  output logic [2*acmp_pkg::NUM_CMP-1:0] POS_SEL,
  output logic [2*acmp_pkg::NUM_CMP-1:0] NEG_SEL,
  output logic [acmp_pkg::NUM_CMP-1:0] POS_CONNECT,
  output logic [acmp_pkg::NUM_CMP-1:0] NEG_CONNECT,
  output logic [acmp_pkg::NUM_CMP-1:0] POS_GROUND,
  // Timer.
  input wire logic TIMER_CLK,
  output logic [acmp_pkg::NUM_CMP-1:0] TIMER_RESULT,
  // Result pins.
  input wire logic [acmp_pkg::NUM_CMP-1:0] PIN_DIR,
  output logic [acmp_pkg::NUM_CMP-1:0] RESULT_PIN_O,
  output logic [acmp_pkg::NUM_CMP-1:0] RESULT_PIN_OE,
  // Edge flags.
  output logic [acmp_pkg::NUM_CMP-1:0] IRQ_FLAG
);

  import acmp_pkg::*;

  localparam logic [1:0] DIV_LAST = 2'(INSTR_CYCLES - 1);

  logic [7:0] ctrl_a_q [NUM_CMP];
  logic [7:0] ctrl_b_q [NUM_CMP];
  logic [1:0] div_q;
  logic instr_tick;
  logic tclk_q;
  logic tclk_fall;
  logic [NUM_CMP-1:0] raw_s;
  logic [NUM_CMP-1:0] enable;
  logic [NUM_CMP-1:0] result_d;
  logic [NUM_CMP-1:0] result_q;
  logic [NUM_CMP-1:0] sync_q;
  logic [NUM_CMP-1:0] ext_result;
  logic [NUM_CMP-1:0] flag_clear;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [3:0] sel_a [NUM_CMP];
  logic [3:0] sel_b [NUM_CMP];

  assign sel_a[0] = OFF_CTRL_A1;
  assign sel_a[1] = OFF_CTRL_A2;
  assign sel_b[0] = OFF_CTRL_B1;
  assign sel_b[1] = OFF_CTRL_B2;

  // Instruction cycle divider; one enable pulse every four clocks.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_q <= 2'h0;
    end else if (div_q == DIV_LAST) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  assign instr_tick = (div_q == DIV_LAST);

  // Timer clock is sampled; its falling edge is the update moment.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tclk_q <= 1'b0;
    end else begin
      tclk_q <= TIMER_CLK;
    end
  end

  assign tclk_fall = tclk_q & ~TIMER_CLK;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        ctrl_a_q[i] <= RST_CTRL_A;
        ctrl_b_q[i] <= RST_CTRL_B;
      end
    end else if (WR_EN) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (ADDR == sel_a[i]) begin
          ctrl_a_q[i] <= WDATA & MASK_CTRL_A;
        end
        if (ADDR == sel_b[i]) begin
          ctrl_b_q[i] <= WDATA & MASK_CTRL_B;
        end
      end
    end
  end

  acmp_sync #(
    .WIDTH(NUM_CMP)
  ) u_sync (
    .clk(MCLK),
    .rst_n(RESET_N),
    .async_in(CMP_RAW),
    .sync_out(raw_s)
  );

  // The core output is gated before the inversion, so a polarity or
  // enable change alone still moves the result and can be flagged.
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      enable[i] = ctrl_a_q[i][A_ENABLE_BIT];
      result_d[i] = (enable[i] & raw_s[i]) ^ ctrl_a_q[i][A_INVERT_BIT];
      ext_result[i] = ctrl_a_q[i][A_SYNC_BIT] ? sync_q[i] : result_d[i];
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      result_q <= '0;
    end else if (instr_tick) begin
      result_q <= result_d;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_q <= '0;
    end else if (tclk_fall) begin
      sync_q <= result_d;
    end
  end

  // The pin path is not gated by the enable bit on purpose.
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      RESULT_PIN_OE[i] = ctrl_a_q[i][A_PIN_EN_BIT] & ~PIN_DIR[i];
      RESULT_PIN_O[i] = ext_result[i];
      TIMER_RESULT[i] = ext_result[i];
      CMP_POWER_ON[i] = enable[i];
      SPEED_POWER[i] = ctrl_a_q[i][A_SPEED_BIT];
      HYST_EN[i] = ctrl_a_q[i][A_HYST_BIT];
      POS_SEL[2*i +: 2] = ctrl_b_q[i][B_POS_LSB +: 2];
      NEG_SEL[2*i +: 2] = ctrl_b_q[i][B_NEG_LSB +: 2];
      POS_CONNECT[i] = enable[i];
      NEG_CONNECT[i] = enable[i];
      POS_GROUND[i] = enable[i] && (i == 1) &&
        (ctrl_b_q[i][B_POS_LSB +: 2] == POS_CODE_FOURTH);
    end
  end

  // Flags clear by writing one to their bit of the flag register.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_edge
      assign flag_clear[gi] = WR_EN && (ADDR == OFF_FLAGS) && WDATA[gi];
      acmp_edge u_edge (
        .clk(MCLK),
        .rst_n(RESET_N),
        .value(result_q[gi]),
        .rise_en(ctrl_b_q[gi][B_RISE_BIT]),
        .fall_en(ctrl_b_q[gi][B_FALL_BIT]),
        .clear(flag_clear[gi]),
        .flag(IRQ_FLAG[gi])
      );
    end
  endgenerate

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rdata_d = 8'h00;
    for (int i = 0; i < NUM_CMP; i++) begin
      if (ADDR == sel_a[i]) begin
        rdata_d = ctrl_a_q[i] & MASK_CTRL_A;
        rdata_d[A_RESULT_BIT] = result_q[i];
      end
      if (ADDR == sel_b[i]) begin
        rdata_d = ctrl_b_q[i] & MASK_CTRL_B;
      end
    end
    if (ADDR == OFF_MIRROR) begin
      rdata_d[M_FIRST_BIT] = result_q[0];
      rdata_d[M_SECOND_BIT] = result_q[1];
    end
    if (ADDR == OFF_FLAGS) begin
      rdata_d[NUM_CMP-1:0] = IRQ_FLAG;
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= 8'h00;
    end else if (RD_EN) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign RDATA = rdata_q;

  chk_instr_period: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick period wrong");

  chk_result_hold: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    !instr_tick |=> $stable(result_q))
    else $error("result changed between instruction ticks");

  chk_result_follow: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    instr_tick |=> result_q[0] ==
      ($past(raw_s[0] & ctrl_a_q[0][A_ENABLE_BIT]) ^
       $past(ctrl_a_q[0][A_INVERT_BIT])))
    else $error("latched result does not match inverted core");

  chk_mirror_read: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    RD_EN && ADDR == OFF_MIRROR |=> RDATA == {6'h00, $past(result_q)})
    else $error("mirror read mismatch");

  chk_pin_route: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    WR_EN && ADDR == OFF_CTRL_A1 && WDATA[A_PIN_EN_BIT] && !PIN_DIR[0]
      ##1 !PIN_DIR[0] |-> RESULT_PIN_OE[0])
    else $error("pin not driven after enable");

  chk_speed_write: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    WR_EN && ADDR == OFF_CTRL_A1 |=> SPEED_POWER[0] == $past(WDATA[2]))
    else $error("speed select not forwarded");

  chk_disabled_inputs: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    !ctrl_a_q[0][A_ENABLE_BIT] |-> !POS_CONNECT[0] && !NEG_CONNECT[0]
      && !CMP_POWER_ON[0])
    else $error("disabled comparator still connected");

  chk_sync_hold: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    ctrl_a_q[0][A_SYNC_BIT] && !tclk_fall ##1 ctrl_a_q[0][A_SYNC_BIT]
      |-> $stable(TIMER_RESULT[0]))
    else $error("synced output moved without timer fall");

  chk_rise_flag: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    $rose(result_q[0]) && ctrl_b_q[0][B_RISE_BIT] |=> IRQ_FLAG[0])
    else $error("rising edge not flagged");

  chk_clear_loses: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    $fell(result_q[0]) && ctrl_b_q[0][B_FALL_BIT] && flag_clear[0]
      |=> IRQ_FLAG[0])
    else $error("edge lost against clear");

endmodule

// >>> rtl/acmp_pkg.sv
/*
  Constants for the analog comparator control block: register offsets,
  field positions, reset values, write masks and the instruction-cycle
  timing. Assumes a single 100 MHz clock and an 8-bit register port.
*/
package acmp_pkg;

  // Structure.
  localparam int unsigned NUM_CMP = 2;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [3:0] OFF_CTRL_A1 = 4'h0;
  localparam logic [3:0] OFF_CTRL_B1 = 4'h1;
  localparam logic [3:0] OFF_CTRL_A2 = 4'h2;
  localparam logic [3:0] OFF_CTRL_B2 = 4'h3;
  localparam logic [3:0] OFF_MIRROR = 4'h4;
  localparam logic [3:0] OFF_FLAGS = 4'h5;

  // Fields of comparator_control_a.
  localparam int unsigned A_ENABLE_BIT = 7;
  localparam int unsigned A_RESULT_BIT = 6;
  localparam int unsigned A_PIN_EN_BIT = 5;
  localparam int unsigned A_INVERT_BIT = 4;
  localparam int unsigned A_SPEED_BIT = 2;
  localparam int unsigned A_HYST_BIT = 1;
  localparam int unsigned A_SYNC_BIT = 0;

  // Fields of comparator_control_b.
  localparam int unsigned B_RISE_BIT = 7;
  localparam int unsigned B_FALL_BIT = 6;
  localparam int unsigned B_POS_LSB = 4;
  localparam int unsigned B_NEG_LSB = 0;

  // Fields of comparator_output_mirror.
  localparam int unsigned M_FIRST_BIT = 0;
  localparam int unsigned M_SECOND_BIT = 1;

  // Positive channel code that selects ground on the second comparator.
  localparam logic [1:0] POS_CODE_FOURTH = 2'h3;

  // Reset values and writable bit masks.
  localparam logic [7:0] RST_CTRL_A = 8'h04;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] MASK_CTRL_A = 8'hB7;
  localparam logic [7:0] MASK_CTRL_B = 8'hF3;

  // Timing: the instruction cycle is four system clocks.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INSTR_PERIOD_NS = 40;
  localparam int unsigned INSTR_CYCLES = INSTR_PERIOD_NS / CLK_PERIOD_NS;

endpackage

// >>> rtl/acmp_sync.sv
/*
  Two-stage synchroniser for a vector of independent level signals.
  Assumes each bit is a slow level; no bus coherence is kept.
*/
`timescale 1ns/1ps
module acmp_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Data.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// >>> rtl/acmp_edge.sv
/*
  Edge detector and sticky flag for one comparator result.
  Assumes the watched value is a flip-flop output in the same clock domain.
*/
`timescale 1ns/1ps
module acmp_edge (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Watched value and edge enables.
  input wire logic value,
  input wire logic rise_en,
  input wire logic fall_en,
  // Software clear.
  input wire logic clear,
  output logic flag
);

  logic prev_q;
  logic hit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= value;
    end
  end

  assign hit = (rise_en & value & ~prev_q) | (fall_en & ~value & prev_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (hit) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule

// >>> testbench/acmp_core_model.sv
/*
  Behavioural model of the two analog cores and of the timer clock source.
  Assumes the bench commands the input relation and timer activity.
*/
`timescale 1ns/1ps
module acmp_core_model (
  // Clock.
  input wire logic mclk,
  // Commands from the bench and power from the block.
  input wire logic [1:0] gt,
  input wire logic [1:0] power_on,
  input wire logic timer_run,
  // Outputs to the block.
  output logic [1:0] cmp_raw,
  output logic timer_clk
);
  logic [1:0] tdiv;
  initial begin
    cmp_raw = 2'h0;
    timer_clk = 1'b0;
    tdiv = 2'h0;
  end
  // Raw result bit.
  // An unpowered core toggles every cycle, so a missing gate cannot hide.
  always @(posedge mclk) begin
    cmp_raw <= #3 (power_on & gt) | (~power_on & ~cmp_raw);
  end
  // Timer clock source.
  // The source stands still while stopped, as a gated timer clock does.
  always @(posedge mclk) begin
    if (timer_run) begin
      tdiv <= tdiv + 2'h1;
      if (tdiv == 2'h3) begin
        timer_clk <= ~timer_clk;
      end
    end
  end
endmodule

// >>> testbench/test_analog_comparator_control.sv
/*
  Self-checking bench for the comparator control block.
  Assumes the core model drives the analog and timer inputs.
*/
`timescale 1ns/1ps
module test_analog_comparator_control;
  import acmp_pkg::*;
  logic mclk = 1'b0;
  logic rst_n, wr_en, rd_en, tclk, trun;
  logic [3:0] addr, ca, cb, neg_sel, pos_sel;
  logic [7:0] wdata, rdata;
  logic [1:0] raw, power, speed, hyst, pcon, ncon, pgnd, tres;
  logic [1:0] pin_dir, pin_o, pin_oe, irq, gt, kk;
  int err_total = 0;
  int checks_done = 0;
  always #5 mclk = ~mclk;
  acmp_top acmp_top_i (.MCLK(mclk), .RESET_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata),
    .CMP_RAW(raw), .CMP_POWER_ON(power), .SPEED_POWER(speed),
    .HYST_EN(hyst), .POS_SEL(pos_sel), .NEG_SEL(neg_sel),
    .POS_CONNECT(pcon), .NEG_CONNECT(ncon), .POS_GROUND(pgnd),
    .TIMER_CLK(tclk), .TIMER_RESULT(tres), .PIN_DIR(pin_dir),
    .RESULT_PIN_O(pin_o), .RESULT_PIN_OE(pin_oe), .IRQ_FLAG(irq));
  acmp_core_model acmp_core_model_i (.mclk(mclk), .gt(gt),
    .power_on(power), .timer_run(trun), .cmp_raw(raw), .timer_clk(tclk));
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chkb(input logic got, exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    chk8(rdata, exp, "read data");
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wait_irq(input int i);
    int n;
    n = 0;
    while (irq[i] !== 1'b1 && n < 16) begin
      settle(1);
      n++;
    end
    chkb(irq[i], 1'b1, "flag set");
    if (irq[i] !== 1'b1) begin
      conclude();
    end
  endtask
  // A hung run still reaches the verdict.
  initial begin
    #500000;
    err_total++;
    $display("CHECK FAILED t=%0t run limit reached", $time);
    conclude();
  end
  initial begin
    {rst_n, wr_en, rd_en, trun, addr, wdata, gt, pin_dir} = '0;
    repeat (20) @(posedge mclk);
    #1;
    chk8({6'h00, speed}, 8'h03, "speed at reset");
    rst_n <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      rd(4'(2 * i), RST_CTRL_A);
      rd(4'(2 * i + 1), RST_CTRL_B);
    end
    rd(OFF_MIRROR, 8'h00);
    rd(4'hF, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      ca = 4'(2 * i);
      cb = 4'(2 * i + 1);
      wr(ca, 8'h84);
      for (int k = 0; k < 4; k++) begin
        kk = 2'(k);
        wr(cb, {2'b11, kk, 2'b11, kk});
        rd(cb, {2'b11, kk, 2'b00, kk});
        chk8(8'(pos_sel[2*i+:2]), 8'(kk), "positive code");
        chk8(8'(neg_sel[2*i+:2]), 8'(kk), "negative code");
        chkb(pgnd[i], i == 1 && k == 3, "ground select");
      end
      chkb(pcon[i] & ncon[i] & power[i], 1'b1, "connected");
      gt[i] <= 1'b1;
      settle(10);
      rd(ca, 8'hC4);
      rd(OFF_MIRROR, 8'(1 << i));
      chkb(tres[i], 1'b1, "timer result");
      wr(cb, 8'h40);
      wr(OFF_FLAGS, 8'h03);
      settle(6);
      chkb(irq[i], 1'b0, "flag cleared");
      gt[i] <= 1'b0;
      wait_irq(i);
      rd(ca, 8'h84);
      wr(cb, 8'h80);
      wr(OFF_FLAGS, 8'h03);
      wr(ca, 8'h94);
      wait_irq(i);
      rd(ca, 8'hD4);
      chkb(tres[i], 1'b1, "inverted timer result");
      wr(OFF_FLAGS, 8'h03);
      gt[i] <= 1'b1;
      settle(12);
      chkb(irq[i], 1'b0, "no flag on fall");
      wr(ca, 8'hB4);
      settle(2);
      chkb(pin_oe[i], 1'b1, "pin driven");
      chkb(pin_o[i], 1'b0, "pin value");
      pin_dir[i] <= 1'b1;
      settle(2);
      chkb(pin_oe[i], 1'b0, "pin released");
      pin_dir[i] <= 1'b0;
      wr(ca, 8'h24);
      settle(10);
      chkb(pin_oe[i], 1'b1, "pin without enable");
      chkb(pcon[i] | ncon[i] | power[i], 1'b0, "disconnected");
      chkb(tres[i], 1'b0, "disabled result");
      rd(ca, 8'h24);
      wr(OFF_FLAGS, 8'h03);
      wr(ca, 8'h14);
      wait_irq(i);
      // The flag rose one edge after a tick, which fixes the tick phase.
      // The invert drop then meets the second clear in the same cycle.
      wr(cb, 8'hC0);
      wr(ca, 8'h04);
      wr(OFF_FLAGS, 8'h03);
      wr(OFF_FLAGS, 8'h03);
      settle(1);
      chkb(irq[i], 1'b1, "edge beats clear");
      rd(OFF_FLAGS, 8'(1 << i));
      wr(ca, 8'h82);
      settle(1);
      chkb(speed[i], 1'b0, "low power");
      chkb(hyst[i], 1'b1, "hysteresis");
      wr(ca, 8'h81);
      gt[i] <= 1'b0;
      trun <= 1'b1;
      settle(20);
      trun <= 1'b0;
      chkb(tres[i], 1'b0, "sync follows");
      gt[i] <= 1'b1;
      settle(16);
      rd(ca, 8'hC1);
      chkb(tres[i], 1'b0, "sync holds");
      trun <= 1'b1;
      settle(12);
      chkb(tres[i], 1'b1, "sync updates");
      trun <= 1'b0;
      gt[i] <= 1'b0;
      wr(ca, 8'h04);
      wr(cb, 8'h00);
      wr(OFF_FLAGS, 8'h03);
      settle(10);
      $display("comparator %0d test done", i);
    end
    wr(OFF_CTRL_A1, 8'hB7);
    rst_n <= 1'b0;
    settle(2);
    rst_n <= 1'b1;
    rd(OFF_CTRL_A1, RST_CTRL_A);
    $display("second reset test done");
    conclude();
  end
endmodule
